/* pkg/bpl_pkg.sv */
// Constants, masks and carrier types for the bidirectional port lines block.
//
// Behaviour
// - Sample every pin each state time, any direction.
// - Input line: write latch, read pin.
// - Input line: read-modify-write sources pin, stores latch.
// - Direction one drives written value on pin.
// - Output line: reads return output latch.
// - Some ports: per-bit push-pull or open drain.
// - Threshold chosen per byte via select bits, except port six, which has none.
// - Direction and drive independent of threshold.
// - Alternate output drives pin only when output.
// - Pin is latch AND alternate data, except PWM.
// - Output line feeds latch to alternate input.
// - After reset every line is input.
// - Some alternate outputs self-configure as output.
// - External bus mode switches direction by hardware.
// - Port three lacks line fourteen entirely.
// - Port five is sixteen input-only lines.
package bpl_pkg;

  // ----------------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------------
  localparam int NUM_PORTS    = 9;   // Ports zero to eight.
  localparam int PORT_W       = 16;  // Widest port in lines.
  localparam int CLK_PERIOD_NS = 8;  // Bus clock period.
  localparam int STATE_TIME_NS = 16; // One state time.
  localparam int STATE_CYCLES  = (STATE_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_DATA = 12'h000; // Output latch per port.
  localparam logic [11:0] OFS_DIR  = 12'h040; // Line direction bits.
  localparam logic [11:0] OFS_ODP  = 12'h080; // Drain mode select.
  localparam logic [11:0] OFS_SET  = 12'h0c0; // Read-modify-write set.
  localparam logic [11:0] OFS_CLR  = 12'h100; // Read-modify-write clear.
  localparam logic [11:0] OFS_THR  = 12'h140; // Threshold main and ext.
  localparam logic [3:0]  THR_MAIN_IDX = 4'h0; // Main select word.
  localparam logic [3:0]  THR_EXT_IDX  = 4'h1; // Extended select word.

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_LATCH = 16'h0000;
  localparam logic [15:0] RST_DIR   = 16'h0000; // All lines input.
  localparam logic [15:0] RST_ODP   = 16'h0000;
  localparam logic [6:0]  RST_THR_MAIN = 7'h00;
  localparam logic [5:0]  RST_THR_EXT  = 6'h00;

  // ----------------------------------------------------------------------
  // Per-port line masks, port eight in the top word
  // ----------------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0][15:0] IMPL_MASK = {16'h00ff, 16'h00ff,
    16'h00ff, 16'hffff, 16'h00ff, 16'hbfff, 16'hffff, 16'hffff, 16'hffff};
  localparam logic [NUM_PORTS-1:0][15:0] OUT_MASK = {16'h00ff, 16'h00ff,
    16'h00ff, 16'h0000, 16'h00ff, 16'hbfff, 16'hffff, 16'hffff, 16'hffff};
  localparam logic [NUM_PORTS-1:0][15:0] OD_MASK = {16'h00ff, 16'h00ff,
    16'h00ff, 16'h0000, 16'h00ff, 16'hbfff, 16'hffff, 16'h0000, 16'h0000};
  localparam logic [NUM_PORTS-1:0]       BUS_PORTS = 9'h003;

  // Threshold select index per byte: 0-6 main, 7-12 ext, 15 none.
  localparam logic [NUM_PORTS-1:0][3:0] THR_LO = {4'h6, 4'h5, 4'hf,
    4'hb, 4'h4, 4'h9, 4'h7, 4'h2, 4'h0};
  localparam logic [NUM_PORTS-1:0][3:0] THR_HI = {4'hf, 4'hf, 4'hf,
    4'hc, 4'hf, 4'ha, 4'h8, 4'h3, 4'h1};

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] o;  // Level driven while enabled.
    logic [15:0] oe; // High while the line drives its pin.
  } bpl_pad_drv_t;

  typedef struct packed {
    logic [15:0] en;       // Alternate output selected per line.
    logic [15:0] data;     // Alternate output data.
    logic [15:0] bypass;   // Line is a PWM output, latch not ANDed.
    logic [15:0] auto_dir; // Alternate forces output after reset.
  } bpl_alt_out_t;

  typedef struct packed {
    logic en;    // Multiplexed external bus enabled on ports 0 and 1.
    logic drive; // Bus phase drives address when high.
  } bpl_bus_ctl_t;

endpackage

/* rtl/bpl_ports.sv */
// Parallel port lines with APB control registers and alternate paths.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
module bpl_ports #(
  parameter int STATE_DIV = bpl_pkg::STATE_CYCLES // Cycles per state time.
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [8:0][15:0]             pad_i,
  output bpl_pkg::bpl_pad_drv_t [8:0]       pad_drv,
  input  wire bpl_pkg::bpl_alt_out_t [8:0]  alt_out,
  input  wire bpl_pkg::bpl_bus_ctl_t        bus_ctl,
  output logic      [8:0][15:0]             alt_in,
  output logic      [8:0][1:0]              pad_thr_cmos
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (STATE_DIV < 1 || STATE_DIV > 255) begin : g_bad_div
    $error("STATE_DIV must lie between 1 and 255.");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [8:0][15:0] latch;          // Output latches.
  logic [8:0][15:0] next_latch;
  logic [8:0][15:0] dir;            // Line direction bits.
  logic [8:0][15:0] next_dir;
  logic [8:0][15:0] odp;            // Drain mode select bits.
  logic [8:0][15:0] next_odp;
  logic [6:0]       thr_main;       // Threshold select main.
  logic [6:0]       next_thr_main;
  logic [5:0]       thr_ext;        // Threshold select ext.
  logic [5:0]       next_thr_ext;
  logic [8:0][15:0] sync1;          // First synchroniser stage.
  logic [8:0][15:0] sync2;          // Second stage.
  logic [8:0][15:0] sync3;          // Third stage.
  logic [8:0][15:0] in_latch;       // Input latches.
  logic [8:0][15:0] next_in_latch;
  logic [7:0]       div_cnt;        // State time divider.
  logic [7:0]       next_div_cnt;
  logic             state_tick;     // One pulse per state time.

  // ----------------------------------------------------------------------
  // Combinational views of the lines
  // ----------------------------------------------------------------------
  logic [8:0][15:0] eff_dir;        // Direction after hardware overrides.
  logic [8:0][15:0] out_val;        // Value the line wants on its pin.
  logic [8:0][15:0] rb;             // Software read view of each port.
  logic [15:0]      thr_all;        // Threshold bits in one vector.

  // Decoded APB fields.
  logic [5:0]       region;         // Which register group.
  logic [3:0]       pidx;           // Port index inside a group.
  logic             hit;            // Address maps to a register.
  logic             wr_en;          // Write takes effect this edge.

  assign region = paddr[11:6];
  assign pidx   = paddr[5:2];
  assign wr_en  = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign thr_all = {3'b000, thr_ext, thr_main};

  // Address decode: five port groups plus the threshold pair.
  always_comb begin
    hit = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      if (region < bpl_pkg::OFS_THR[11:6]) begin
        hit = (pidx < 4'(bpl_pkg::NUM_PORTS));
      end else if (region == bpl_pkg::OFS_THR[11:6]) begin
        hit = (pidx <= bpl_pkg::THR_EXT_IDX);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-line pin logic, one instance per port
  // ----------------------------------------------------------------------
  for (genvar p = 0; p < bpl_pkg::NUM_PORTS; p++) begin : g_port
    logic [15:0] od_eff; // Open drain bits that apply to this port.
    logic [15:0] bus_dir; // Direction while the external bus owns it.

    // Hardware overrides direction while the bus owns the port.
    assign bus_dir = {16{bus_ctl.drive}};
    assign eff_dir[p] = bpl_pkg::OUT_MASK[p] &
      ((bpl_pkg::BUS_PORTS[p] && bus_ctl.en) ? bus_dir :
       (dir[p] | alt_out[p].auto_dir));

    // Alternate data is ANDed with the latch unless the line is PWM.
    // The choice is made bit by bit, since PWM lines sit among others.
    assign out_val[p] = (alt_out[p].en & alt_out[p].bypass &
      alt_out[p].data) |
      (alt_out[p].en & ~alt_out[p].bypass & alt_out[p].data &
       latch[p]) |
      (~alt_out[p].en & latch[p]);

    // Open drain only pulls low, so a high value releases the pin.
    assign od_eff = odp[p] & bpl_pkg::OD_MASK[p];
    assign pad_drv[p].oe = eff_dir[p] & ~(od_eff & out_val[p]);
    assign pad_drv[p].o  = out_val[p] & ~od_eff;

    // Reads see the latch on outputs and the sampled pin on inputs.
    assign rb[p] = bpl_pkg::IMPL_MASK[p] &
      ((eff_dir[p] & latch[p]) | (~eff_dir[p] & in_latch[p]));

    // An output line hands its latch to the peripheral input.
    assign alt_in[p] = bpl_pkg::IMPL_MASK[p] &
      ((eff_dir[p] & latch[p]) | (~eff_dir[p] & in_latch[p]));

    // Pad threshold selects per byte.
    assign pad_thr_cmos[p] = {thr_all[bpl_pkg::THR_HI[p]],
                              thr_all[bpl_pkg::THR_LO[p]]};
  end

  // ----------------------------------------------------------------------
  // Register file next values
  // ----------------------------------------------------------------------
  // Writes land at the access edge and drive pins the next cycle.
  always_comb begin
    next_latch    = latch;
    next_dir      = dir;
    next_odp      = odp;
    next_thr_main = thr_main;
    next_thr_ext  = thr_ext;
    prdata        = 32'h0000_0000;
    pslverr       = psel & penable & ~hit;
    for (int p = 0; p < bpl_pkg::NUM_PORTS; p++) begin
      if (pidx == 4'(p)) begin
        // Plain write lands in the latch whatever the direction.
        if (wr_en && region == bpl_pkg::OFS_DATA[11:6]) begin
          next_latch[p] = pwdata[15:0] & bpl_pkg::IMPL_MASK[p];
        end
        if (wr_en && region == bpl_pkg::OFS_DIR[11:6]) begin
          next_dir[p] = pwdata[15:0] & bpl_pkg::OUT_MASK[p];
        end
        if (wr_en && region == bpl_pkg::OFS_ODP[11:6]) begin
          next_odp[p] = pwdata[15:0] & bpl_pkg::OD_MASK[p];
        end
        // Set and clear read the line view, modify, and store the latch.
        if (wr_en && region == bpl_pkg::OFS_SET[11:6]) begin
          next_latch[p] = rb[p] | (pwdata[15:0] &
                                   bpl_pkg::IMPL_MASK[p]);
        end
        if (wr_en && region == bpl_pkg::OFS_CLR[11:6]) begin
          next_latch[p] = rb[p] & ~pwdata[15:0];
        end
        // Read data for the port groups.
        if (region == bpl_pkg::OFS_DATA[11:6]) begin
          prdata = {16'h0000, rb[p]};
        end else if (region == bpl_pkg::OFS_DIR[11:6]) begin
          prdata = {16'h0000, dir[p]};
        end else if (region == bpl_pkg::OFS_ODP[11:6]) begin
          prdata = {16'h0000, odp[p]};
        end else if (region == bpl_pkg::OFS_SET[11:6] ||
                     region == bpl_pkg::OFS_CLR[11:6]) begin
          prdata = {16'h0000, latch[p]};
        end
      end
    end
    // Threshold selects, kept per byte.
    if (region == bpl_pkg::OFS_THR[11:6]) begin
      if (pidx == bpl_pkg::THR_MAIN_IDX) begin
        prdata = {25'h0, thr_main};
        if (wr_en) begin
          next_thr_main = pwdata[6:0];
        end
      end else if (pidx == bpl_pkg::THR_EXT_IDX) begin
        prdata = {26'h0, thr_ext};
        if (wr_en) begin
          next_thr_ext = pwdata[5:0];
        end
      end
    end
    if (!hit) begin
      prdata = 32'h0000_0000;
    end
  end

  // Register file flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch    <= {bpl_pkg::NUM_PORTS{bpl_pkg::RST_LATCH}};
      dir      <= {bpl_pkg::NUM_PORTS{bpl_pkg::RST_DIR}};
      odp      <= {bpl_pkg::NUM_PORTS{bpl_pkg::RST_ODP}};
      thr_main <= bpl_pkg::RST_THR_MAIN;
      thr_ext  <= bpl_pkg::RST_THR_EXT;
    end else begin
      latch    <= next_latch;
      dir      <= next_dir;
      odp      <= next_odp;
      thr_main <= next_thr_main;
      thr_ext  <= next_thr_ext;
    end
  end

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  // A bit is taken only once stages two and three agree, on each tick.
  // A bit still in flight between the stages keeps its old value instead.
  always_comb begin
    state_tick    = (div_cnt == 8'(STATE_DIV - 1));
    next_div_cnt  = state_tick ? 8'h00 : div_cnt + 8'h01;
    next_in_latch = in_latch;
    if (state_tick) begin
      for (int p = 0; p < bpl_pkg::NUM_PORTS; p++) begin
        next_in_latch[p] = bpl_pkg::IMPL_MASK[p] &
          ((~(sync2[p] ^ sync3[p]) & sync3[p]) |
           ((sync2[p] ^ sync3[p]) & in_latch[p]));
      end
    end
  end

  // Sampling flops; the first stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      in_latch <= '0;
      div_cnt  <= 8'h00;
    end else begin
      sync1    <= pad_i;
      sync2    <= sync1;
      sync3    <= sync2;
      in_latch <= next_in_latch;
      div_cnt  <= next_div_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Port two carries the register checks, port four the alternate path.
  // A write access to one register group of port two.
  sequence s_wr(logic [11:0] base);
    psel && penable && pwrite && paddr == base + 12'h008;
  endsequence

  AST_SAMPLE: assert property (state_tick && sync2[2] == sync3[2]
    |=> in_latch[2] == ($past(sync3[2]) & bpl_pkg::IMPL_MASK[2]))
    else $error("Input latch missed an agreed pin sample.");
  AST_RD_PIN: assert property (psel && !pwrite && paddr == 12'h008
    && dir[2] == 16'h0000 && !bus_ctl.en && alt_out[2].auto_dir == 0
    |-> prdata[15:0] == in_latch[2])
    else $error("Input line read did not return the pin.");
  AST_WR_LATCH: assert property (s_wr(bpl_pkg::OFS_DATA)
    |=> latch[2] == $past(pwdata[15:0]))
    else $error("Data write did not reach the latch.");
  AST_RMW: assert property (s_wr(bpl_pkg::OFS_SET)
    |=> latch[2] == ($past(rb[2]) | $past(pwdata[15:0])))
    else $error("Set did not start from the read view.");
  AST_RD_OUT: assert property (eff_dir[2] == 16'hffff
    |-> rb[2] == latch[2])
    else $error("Output line read did not return the latch.");
  AST_PUSH: assert property (s_wr(bpl_pkg::OFS_DATA) ##1
    (eff_dir[2][0] && !odp[2][0] && !alt_out[2].en[0])
    |-> pad_drv[2].oe[0] && pad_drv[2].o[0] == $past(pwdata[0]))
    else $error("Output line did not drive the written value.");
  AST_OD: assert property (odp[2][0] && out_val[2][0]
    |-> !pad_drv[2].oe[0])
    else $error("Open drain line drove high.");
  AST_HIZ: assert property (alt_out[4].en[4] && !dir[4][4]
    && !alt_out[4].auto_dir[4] |-> !pad_drv[4].oe[4])
    else $error("Input line drove its pin.");
  AST_AND: assert property (alt_out[4].en[4] && !alt_out[4].bypass[4]
    && !odp[4][4] |-> pad_drv[4].o[4] == (alt_out[4].data[4] & latch[4][4]))
    else $error("Alternate data not ANDed with latch.");
  AST_PWM: assert property (alt_out[4].en[0] && alt_out[4].bypass[0]
    && !odp[4][0] |-> pad_drv[4].o[0] == alt_out[4].data[0])
    else $error("PWM line did not bypass the latch.");
  AST_LOOP: assert property (eff_dir[2][3]
    |-> alt_in[2][3] == latch[2][3])
    else $error("Output line did not feed latch back.");
  AST_BUS: assert property (bus_ctl.en |->
    pad_drv[0].oe == {16{bus_ctl.drive}})
    else $error("Bus mode did not steer direction.");
  AST_HOLD: assert property (state_tick && sync2[2][0] != sync3[2][0]
    |=> in_latch[2][0] == $past(in_latch[2][0]))
    else $error("Input latch took a pin bit still settling.");
  AST_CLR: assert property (s_wr(bpl_pkg::OFS_CLR)
    |=> latch[2] == ($past(rb[2]) & ~$past(pwdata[15:0])))
    else $error("Clear did not start from the read view.");
  AST_THR: assert property (pad_thr_cmos[2] == thr_ext[1:0])
    else $error("Port two threshold not taken from its byte bits.");
  AST_NO_DRIVE: assert property (pad_drv[5].oe == 16'h0000
    && !pad_drv[3].oe[14])
    else $error("Input-only or missing line drove a pin.");

endmodule

/* testbench/bpl_pin_model.sv */
// Behavioural pins and external drivers facing the port block.
`timescale 1ns/100ps
module bpl_pin_model (
  input  wire bpl_pkg::bpl_pad_drv_t [8:0] pad_drv,
  input  wire logic [8:0][15:0]            ext_val,
  input  wire logic [8:0][15:0]            ext_en,
  output logic      [8:0][15:0]            pad_i
);
  // --------------------------------------------------------------------
  // Pin levels
  // --------------------------------------------------------------------
  // Device drive wins, then an outside driver, else the pull-up holds 1.
  always_comb begin
    for (int p = 0; p < 9; p++) begin
      pad_i[p] = (pad_drv[p].oe & pad_drv[p].o)
        | (~pad_drv[p].oe & ext_en[p] & ext_val[p])
        | (~pad_drv[p].oe & ~ext_en[p]);
    end
  end
endmodule

/* testbench/bpl_ports_bench.sv */
// Self-checking bench for the port lines block.
`timescale 1ns/100ps
module bpl_ports_bench;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic                        pclk, presetn, psel, penable, pwrite;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata;
  logic                        pready, pslverr;
  logic [8:0][15:0]            pad_i, ext_val, ext_en, alt_in;
  logic [8:0][1:0]             pad_thr_cmos;
  bpl_pkg::bpl_pad_drv_t [8:0] pad_drv;
  bpl_pkg::bpl_alt_out_t [8:0] alt_out;
  bpl_pkg::bpl_bus_ctl_t       bus_ctl;
  int                          num_errors, num_checks, cyc;
  logic [15:0]                 lfsr;
  logic [32:0]                 rq[$]; // Expected {pslverr, prdata}.

  // The clock toggles every half period of 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  bpl_ports #(.STATE_DIV(2)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_i(pad_i), .pad_drv(pad_drv),
    .alt_out(alt_out), .bus_ctl(bus_ctl), .alt_in(alt_in),
    .pad_thr_cmos(pad_thr_cmos));

  bpl_pin_model pm (.pad_drv(pad_drv), .ext_val(ext_val),
    .ext_en(ext_en), .pad_i(pad_i));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Next pseudo-random word from the feedback shift register.
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Byte address of one port's word in a register group.
  function automatic logic [11:0] ad(input logic [11:0] o, input int p);
    return o + 12'(4 * p);
  endfunction

  // Compares one value and counts the outcome.
  task automatic cmp(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Outputs launched by the access edge are read one edge later.
    @(posedge pclk);
  endtask

  // A read notes its expected result before the transfer starts.
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic err);
    rq.push_back({err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Lets one edge pass so that new alternate inputs settle.
  task automatic settle();
    @(posedge pclk);
  endtask

  // Watches completed reads and compares them with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) begin
        cmp("read queue", 32'h0000_0001, 32'h0000_0000);
      end else begin
        cmp("prdata", rq[0][31:0], prdata);
        cmp("pslverr", {31'h0, rq[0][32]}, {31'h0, pslverr});
        void'(rq.pop_front());
      end
    end
  end

  // Cuts a hang short after a generous cycle ceiling.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    logic [15:0] v, l, t, u, d;
    logic [12:0] thr;
    logic [3:0]  lo, hi;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    alt_out = '0;
    bus_ctl = '0;
    ext_val = '0;
    ext_en = '1;
    lfsr = 16'h0056;
    num_errors = 0;
    num_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Every line starts as an input with no drive.
    for (int p = 0; p < 9; p++) begin
      rd(ad(bpl_pkg::OFS_DIR, p), 32'h0, 1'b0);
      cmp("oe", 32'h0, pad_drv[p].oe);
    end
    // Input line: write goes to the latch, read shows the pin.
    v = rnd();
    ext_val[2] <= v;
    apb(1'b1, ad(bpl_pkg::OFS_DATA, 2), {16'h0, rnd()});
    repeat (8) @(posedge pclk);
    rd(ad(bpl_pkg::OFS_DATA, 2), {16'h0, v}, 1'b0);
    cmp("alt_in", v, alt_in[2]);
    // Set from the pin view, then turn the line round to output.
    t = rnd();
    l = v | t;
    apb(1'b1, ad(bpl_pkg::OFS_SET, 2), {16'h0, t});
    apb(1'b1, ad(bpl_pkg::OFS_DIR, 2), 32'h0000_ffff);
    cmp("o", l, pad_drv[2].o);
    cmp("oe", 16'hffff, pad_drv[2].oe);
    rd(ad(bpl_pkg::OFS_DATA, 2), {16'h0, l}, 1'b0);
    cmp("alt_in", l, alt_in[2]);
    u = rnd();
    l = l & ~u;
    apb(1'b1, ad(bpl_pkg::OFS_CLR, 2), {16'h0, u});
    cmp("o", l, pad_drv[2].o);
    l = rnd();
    apb(1'b1, ad(bpl_pkg::OFS_DATA, 2), {16'h0, l});
    cmp("o", l, pad_drv[2].o);
    // Open drain only pulls low; ports 0 and 1 have no such mode.
    apb(1'b1, ad(bpl_pkg::OFS_ODP, 2), 32'h0000_ffff);
    cmp("oe", 16'(~l), pad_drv[2].oe);
    cmp("o", 16'h0, pad_drv[2].o & pad_drv[2].oe);
    apb(1'b1, ad(bpl_pkg::OFS_ODP, 0), 32'h0000_ffff);
    rd(ad(bpl_pkg::OFS_ODP, 0), 32'h0, 1'b0);
    // Threshold selects per byte, drive left alone.
    t = rnd();
    u = rnd();
    apb(1'b1, bpl_pkg::OFS_THR, {16'h0, t});
    apb(1'b1, bpl_pkg::OFS_THR + 12'h004, {16'h0, u});
    rd(bpl_pkg::OFS_THR, {25'h0, t[6:0]}, 1'b0);
    rd(bpl_pkg::OFS_THR + 12'h004, {26'h0, u[5:0]}, 1'b0);
    thr = {u[5:0], t[6:0]};
    for (int p = 0; p < 9; p++) begin
      lo = bpl_pkg::THR_LO[p];
      hi = bpl_pkg::THR_HI[p];
      cmp("thr", {hi == 4'hf ? 1'b0 : thr[hi],
          lo == 4'hf ? 1'b0 : thr[lo]}, pad_thr_cmos[p]);
    end
    cmp("oe", 16'(~l), pad_drv[2].oe);
    // Alternate output with the line still an input stays off.
    l = rnd() & 16'h00ff;
    d = rnd();
    apb(1'b1, ad(bpl_pkg::OFS_DATA, 4), {16'h0, l});
    alt_out[4] <= '{en: 16'h00ff, data: d, bypass: 16'h000f,
                    auto_dir: 16'h0};
    settle();
    cmp("oe", 16'h0, pad_drv[4].oe);
    apb(1'b1, ad(bpl_pkg::OFS_DIR, 4), 32'h0000_00ff);
    cmp("o", ((d & l & 16'hfff0) | (d & 16'h000f)) & 16'h00ff,
        pad_drv[4].o);
    // A reset-time alternate output drives without a direction bit.
    alt_out[3].auto_dir <= 16'h0001;
    settle();
    cmp("oe", 16'h0001, pad_drv[3].oe);
    // Port three has no line fourteen.
    apb(1'b1, ad(bpl_pkg::OFS_DIR, 3), 32'h0000_ffff);
    apb(1'b1, ad(bpl_pkg::OFS_DATA, 3), 32'h0000_ffff);
    cmp("oe", 16'hbfff, pad_drv[3].oe);
    rd(ad(bpl_pkg::OFS_DATA, 3), 32'h0000_bfff, 1'b0);
    // Port five never drives.
    apb(1'b1, ad(bpl_pkg::OFS_DIR, 5), 32'h0000_ffff);
    rd(ad(bpl_pkg::OFS_DIR, 5), 32'h0, 1'b0);
    cmp("oe", 16'h0, pad_drv[5].oe);
    // External bus mode turns port zero round by hardware.
    apb(1'b1, ad(bpl_pkg::OFS_DIR, 0), 32'h0000_ffff);
    bus_ctl <= '{en: 1'b1, drive: 1'b0};
    settle();
    cmp("oe", 16'h0, pad_drv[0].oe);
    bus_ctl <= '{en: 1'b1, drive: 1'b1};
    settle();
    cmp("oe", 16'hffff, pad_drv[0].oe);
    // An unmapped place answers with an error and reads zero.
    apb(1'b1, 12'h148, 32'hffff_ffff);
    rd(12'h148, 32'h0, 1'b1);
    cmp("reads left", 32'h0, rq.size());
    end_sim();
  end
endmodule
